/* include/pstq_defines.svh */
`ifndef PSTQ_DEFINES_SVH
`define PSTQ_DEFINES_SVH

// register byte offsets on the avalon slave
`define PSTQ_ADDR_CTRL 5'h00
`define PSTQ_ADDR_TIME_LO 5'h04
`define PSTQ_ADDR_TIME_HI 5'h08
`define PSTQ_ADDR_COUNT 5'h0C
`define PSTQ_ADDR_STATUS 5'h10

// control field positions
`define PSTQ_CTRL_EN 0
`define PSTQ_CTRL_METHOD 1
`define PSTQ_CTRL_QUAL_LSB 2
`define PSTQ_CTRL_TRANS 6
`define PSTQ_CTRL_SLOPE 7
`define PSTQ_CTRL_CH_LSB 8

// status field positions
`define PSTQ_STAT_PRESENT 0
`define PSTQ_STAT_QUAL 1
`define PSTQ_STAT_FIRST 2
`define PSTQ_STAT_TCNT_LSB 8

// reset values
`define PSTQ_CTRL_RST 32'h00000000
`define PSTQ_TIME_LO_RST 32'h00000001
`define PSTQ_TIME_HI_RST 1'h0
`define PSTQ_COUNT_RST 24'h000001

// timing, in the units printed
`define PSTQ_CLK_NS 100
`define PSTQ_HOLD_MIN_NS 30
`define PSTQ_GAP_MIN_NS 1
`define PSTQ_WAIT_MIN_NS 10
`define PSTQ_MAX_S 680
`define PSTQ_MAX_EVENTS 15000000

// least times rounded up to whole clock cycles
`define PSTQ_HOLD_MIN_CYC ((`PSTQ_HOLD_MIN_NS + `PSTQ_CLK_NS - 1) / `PSTQ_CLK_NS)
`define PSTQ_GAP_MIN_CYC ((`PSTQ_GAP_MIN_NS + `PSTQ_CLK_NS - 1) / `PSTQ_CLK_NS)
`define PSTQ_WAIT_MIN_CYC ((`PSTQ_WAIT_MIN_NS + `PSTQ_CLK_NS - 1) / `PSTQ_CLK_NS)

`endif

/* include/pstq_pkg.sv */
package pstq_pkg;

  // per-channel pattern selection
  typedef enum logic [1:0] {
    PSTQ_CH_IGNORE = 2'h0,
    PSTQ_CH_ABOVE = 2'h1,
    PSTQ_CH_BELOW = 2'h2,
    PSTQ_CH_IGNORE2 = 2'h3
  } pstq_chsel_t;

  // qualifier codes; pattern method uses 0..7, state method 8..10
  typedef enum logic [3:0] {
    PSTQ_Q_HTIME = 4'h0,
    PSTQ_Q_HEVT = 4'h1,
    PSTQ_Q_INTLT = 4'h2,
    PSTQ_Q_INTGT = 4'h3,
    PSTQ_Q_GAPLT = 4'h4,
    PSTQ_Q_GAPGT = 4'h5,
    PSTQ_Q_WIDLT = 4'h6,
    PSTQ_Q_WIDGT = 4'h7,
    PSTQ_Q_WAIT = 4'h8,
    PSTQ_Q_ANDB = 4'h9,
    PSTQ_Q_NTH = 4'hA
  } pstq_qual_t;

  // avalon handshake states
  typedef enum logic [1:0] {
    PSTQ_BUS_IDLE = 2'b01,
    PSTQ_BUS_ACK = 2'b10
  } pstq_bus_t;

endpackage

/* include/pstq_pat_if.sv */
`timescale 1ns/1ps
interface pstq_pat_if;
  logic [5:0] chSel;
  logic slope;
  logic present;
  logic patEnter;
  logic patExit;
  logic srcEvt;
  modport prod(input chSel, input slope, output present, output patEnter, output patExit, output srcEvt);
  modport cons(output chSel, output slope, input present, input patEnter, input patExit, input srcEvt);
endinterface

/* verilog/pstq_sat_cnt.sv */
`timescale 1ns/1ps
module pstq_sat_cnt #(
  parameter int W = 33
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic inc,
  output logic [W-1:0] value
);
  localparam logic [W-1:0] ALL_ONES = {W{1'b1}};
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  // clear with a coincident increment counts that increment as the first
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      value <= '0;
    else if (clr)
      value <= inc ? {{(W-1){1'b0}}, 1'b1} : '0;
    else if (inc && value != ALL_ONES)
      value <= value + ONE;
  end

  // a full counter must hold, never wrap back to small values
  counter_saturates_a: assert property (@(posedge clk) disable iff (!rstn)
    (value == ALL_ONES && !clr) |=> value == ALL_ONES)
    else $error("counter wrapped past its maximum");
endmodule

/* verilog/pstq_pattern.sv */
`timescale 1ns/1ps
module pstq_pattern
  import pstq_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic [2:0] chanAbove,
  input wire logic srcLevel,
  pstq_pat_if.prod pat
);
  logic [2:0] chSync1;
  logic [2:0] chSync2;
  logic srcSync1;
  logic srcSync2;
  logic srcPrev;
  logic prevPresent;
  logic [2:0] chOk;

  // one channel against its selection; ignored channels always match
  function automatic logic chanMatch(input logic [1:0] sel, input logic above);
    case (sel)
      PSTQ_CH_ABOVE: chanMatch = above;
      PSTQ_CH_BELOW: chanMatch = !above;
      default: chanMatch = 1'b1;
    endcase
  endfunction

  // comparator levels are asynchronous to clk
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      chSync1 <= 3'h0;
      chSync2 <= 3'h0;
      srcSync1 <= 1'h0;
      srcSync2 <= 1'h0;
    end
    else
    begin
      chSync1 <= chanAbove;
      chSync2 <= chSync1;
      srcSync1 <= srcLevel;
      srcSync2 <= srcSync1;
    end
  end

  // pattern is the and of the per-channel matches
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      chOk[i] = chanMatch(pat.chSel[2*i +: 2], chSync2[i]);
  end
  assign pat.present = &chOk;

  // history; a clear resamples so a standing pattern is no transition
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prevPresent <= 1'h0;
      srcPrev <= 1'h0;
    end
    else
    begin
      prevPresent <= pat.present;
      srcPrev <= srcSync2;
    end
  end

  // transitions and source edge events
  assign pat.patEnter = !clr && pat.present && !prevPresent;
  assign pat.patExit = !clr && !pat.present && prevPresent;
  assign pat.srcEvt = !clr && (pat.slope ? (srcPrev && !srcSync2) : (!srcPrev && srcSync2));

  pattern_entry_a: assert property (@(posedge clk) disable iff (!rstn)
    pat.patEnter |-> pat.present && !$past(pat.present))
    else $error("entry flagged without a rising pattern");
endmodule

/* verilog/pstq_top.sv */
`timescale 1ns/1ps
`include "pstq_defines.svh"
// Behaviour
// - pattern is the AND of up to three channel above-level states.
// - each channel selects above, below or ignored.
// - pattern present only when every used channel matches.
// - holdoff and interval qualifiers trigger on entering or exiting, as selected.
// - time holdoff blocks triggers until delay since last trigger; restarts on trigger.
// - interval-less fires on edge arriving within interval of previous edge.
// - interval-greater fires on edge arriving after interval from previous edge.
// - gap-less fires on re-entry within time after last exit.
// - gap-greater fires on re-entry later than time after last exit.
// - gap timer restarts on every exit, triggered or not.
// - width-less times from start, fires at end if shorter.
// - width-greater times from start, fires at end if longer.
// - gap tests fire on entry, width tests fire on exit.
// - pattern method applies exactly one qualifier at a time.
// - state method fires only on source edges in selected pattern state.
// - wait accepts source edges after delay from pattern start, while pattern holds.
// - and-before accepts source edges before window expires and pattern ends.
// - nth-event counts source events from pattern start, fires on reaching count.
// - source edge polarity selectable, rising or falling.
module pstq_top
  import pstq_pkg::*;
#(
  parameter int TW = 33,
  parameter int EW = 24,
  parameter logic [63:0] MAX_TIME_CYC = 64'd`PSTQ_MAX_S * 64'd1000000000 / 64'd`PSTQ_CLK_NS,
  parameter logic [EW-1:0] MAX_EVENTS = EW'(`PSTQ_MAX_EVENTS)
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [2:0] chanAbove,
  input wire logic srcLevel,
  output logic trigOut
);
  localparam logic [TW-1:0] MAX_T = MAX_TIME_CYC[TW-1:0];
  // a restart that also counts leaves the timer at one, never at zero
  localparam logic [TW-1:0] ONE_T = {{(TW-1){1'b0}}, 1'b1};
  localparam logic [TW-1:0] HOLD_MIN = TW'(`PSTQ_HOLD_MIN_CYC);
  localparam logic [TW-1:0] GAP_MIN = TW'(`PSTQ_GAP_MIN_CYC);
  localparam logic [TW-1:0] WAIT_MIN = TW'(`PSTQ_WAIT_MIN_CYC);

  pstq_pat_if pat();

  pstq_bus_t busSt;
  logic [31:0] ctrl_r;
  logic [31:0] timeLo_r;
  logic timeHi_r;
  logic [EW-1:0] count_r;
  logic [7:0] trigCnt_r;
  logic clr_r;
  logic first_r;
  logic first_nxt;
  logic have_r;
  logic have_nxt;
  logic qPrev_r;
  logic regWr;
  logic enable;
  logic method;
  pstq_qual_t qual;
  logic transSel;
  logic q;
  logic qStart;
  logic trans;
  logic fire;
  logic tmrRestart;
  logic evcRestart;
  logic evcInc;
  logic [TW-1:0] tmr;
  logic [EW-1:0] evc;
  logic [EW-1:0] evcBase;
  logic [TW-1:0] limT;
  logic [EW-1:0] limN;
  logic [TW-1:0] minT;

  // keep a programmed time inside the documented span of the qualifier
  function automatic logic [TW-1:0] clampTime(input logic [TW-1:0] v, input logic [TW-1:0] lo);
    if (v < lo)
      clampTime = lo;
    else if (v > MAX_T)
      clampTime = MAX_T;
    else
      clampTime = v;
  endfunction

  // read mux; unmapped addresses read as zero
  function automatic logic [31:0] rdWord(input logic [4:0] a);
    logic [31:0] w;
    w = 32'h00000000;
    case (a)
      `PSTQ_ADDR_CTRL: w = ctrl_r;
      `PSTQ_ADDR_TIME_LO: w = timeLo_r;
      `PSTQ_ADDR_TIME_HI: w = {31'h00000000, timeHi_r};
      `PSTQ_ADDR_COUNT: w = {{(32-EW){1'b0}}, count_r};
      `PSTQ_ADDR_STATUS:
      begin
        w[`PSTQ_STAT_PRESENT] = pat.present;
        w[`PSTQ_STAT_QUAL] = q;
        w[`PSTQ_STAT_FIRST] = first_r;
        w[`PSTQ_STAT_TCNT_LSB +: 8] = trigCnt_r;
      end
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction

  // control fields
  assign enable = ctrl_r[`PSTQ_CTRL_EN];
  assign method = ctrl_r[`PSTQ_CTRL_METHOD];
  assign qual = pstq_qual_t'(ctrl_r[`PSTQ_CTRL_QUAL_LSB +: 4]);
  assign transSel = ctrl_r[`PSTQ_CTRL_TRANS];
  assign pat.chSel = ctrl_r[`PSTQ_CTRL_CH_LSB +: 6];
  assign pat.slope = ctrl_r[`PSTQ_CTRL_SLOPE];
  assign regWr = (busSt == PSTQ_BUS_ACK) && write;

  // fixed one wait state keeps the slave trivial to time
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busSt <= PSTQ_BUS_IDLE;
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end
    else
    begin
      case (busSt)
        PSTQ_BUS_IDLE:
        begin
          if (read || write)
          begin
            busSt <= PSTQ_BUS_ACK;
            waitrequest <= 1'b0;
            if (read)
              readdata <= rdWord(address);
          end
        end
        PSTQ_BUS_ACK:
        begin
          busSt <= PSTQ_BUS_IDLE;
          waitrequest <= 1'b1;
        end
        default:
        begin
          busSt <= PSTQ_BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // register writes take effect at the handshake edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r <= `PSTQ_CTRL_RST;
      timeLo_r <= `PSTQ_TIME_LO_RST;
      timeHi_r <= `PSTQ_TIME_HI_RST;
      count_r <= `PSTQ_COUNT_RST;
    end
    else if (regWr)
    begin
      case (address)
        `PSTQ_ADDR_CTRL: ctrl_r <= writedata;
        `PSTQ_ADDR_TIME_LO: timeLo_r <= writedata;
        `PSTQ_ADDR_TIME_HI: timeHi_r <= writedata[0];
        `PSTQ_ADDR_COUNT: count_r <= writedata[EW-1:0];
        default: ;
      endcase
    end
  end

  // a changed setup gets one cycle of clear before any evaluation
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      clr_r <= 1'b1;
    else
      clr_r <= !enable || (regWr && address == `PSTQ_ADDR_CTRL && writedata != ctrl_r);
  end

  pstq_pattern u_pattern (
    .clk(clk),
    .rstn(rstn),
    .clr(clr_r),
    .chanAbove(chanAbove),
    .srcLevel(srcLevel),
    .pat(pat.prod)
  );

  pstq_sat_cnt #(.W(TW)) u_timer (
    .clk(clk),
    .rstn(rstn),
    .clr(clr_r || tmrRestart),
    .inc(1'b1),
    .value(tmr)
  );

  pstq_sat_cnt #(.W(EW)) u_events (
    .clk(clk),
    .rstn(rstn),
    .clr(clr_r || evcRestart),
    .inc(evcInc),
    .value(evc)
  );

  // limits; the shortest printed time depends on the qualifier
  always_comb
  begin
    case (qual)
      PSTQ_Q_HTIME, PSTQ_Q_INTLT, PSTQ_Q_INTGT: minT = HOLD_MIN;
      PSTQ_Q_WAIT, PSTQ_Q_ANDB: minT = WAIT_MIN;
      default: minT = GAP_MIN;
    endcase
    limT = clampTime(TW'({timeHi_r, timeLo_r}), minT);
    if (count_r == '0)
      limN = {{(EW-1){1'b0}}, 1'b1};
    else if (count_r > MAX_EVENTS)
      limN = MAX_EVENTS;
    else
      limN = count_r;
  end

  // qualifying state for the state method: present, or absent when inverted
  assign q = pat.present ^ transSel;
  assign qStart = q && !qPrev_r;
  assign trans = transSel ? pat.patExit : pat.patEnter;
  assign evcBase = qStart ? '0 : evc;

  // trigger decision; only the selected qualifier is evaluated
  always_comb
  begin
    fire = 1'b0;
    tmrRestart = 1'b0;
    evcRestart = 1'b0;
    evcInc = 1'b0;
    have_nxt = have_r;
    first_nxt = first_r;
    if (!clr_r && enable)
    begin
      if (!method)
      begin
        case (qual)
          PSTQ_Q_HTIME: fire = trans && (first_r || tmr >= limT);
          PSTQ_Q_HEVT:
          begin
            if (trans && (first_r || evc >= limN))
              fire = 1'b1;
            else
              evcInc = trans;
          end
          PSTQ_Q_INTLT, PSTQ_Q_INTGT:
          begin
            if (trans)
            begin
              fire = have_r && ((qual == PSTQ_Q_INTLT) ? (tmr < limT) : (tmr > limT));
              tmrRestart = 1'b1;
              have_nxt = 1'b1;
            end
          end
          PSTQ_Q_GAPLT, PSTQ_Q_GAPGT:
          begin
            if (pat.patExit)
            begin
              tmrRestart = 1'b1;
              have_nxt = 1'b1;
            end
            if (pat.patEnter)
              fire = have_r && ((qual == PSTQ_Q_GAPLT) ? (tmr < limT) : (tmr > limT));
          end
          PSTQ_Q_WIDLT, PSTQ_Q_WIDGT:
          begin
            if (pat.patEnter)
            begin
              tmrRestart = 1'b1;
              have_nxt = 1'b1;
            end
            if (pat.patExit)
              fire = have_r && ((qual == PSTQ_Q_WIDLT) ? (tmr < limT) : (tmr > limT));
          end
          default: fire = 1'b0;
        endcase
        // holdoffs restart on each trigger
        if (fire)
        begin
          first_nxt = 1'b0;
          tmrRestart = tmrRestart || (qual == PSTQ_Q_HTIME);
          evcRestart = (qual == PSTQ_Q_HEVT);
        end
      end
      else
      begin
        // the timer value is stale in the start cycle, so it is excluded there
        case (qual)
          PSTQ_Q_WAIT:
          begin
            tmrRestart = qStart;
            fire = q && !qStart && pat.srcEvt && tmr >= limT;
          end
          PSTQ_Q_ANDB:
          begin
            tmrRestart = qStart;
            fire = q && pat.srcEvt && (qStart || tmr < limT);
          end
          PSTQ_Q_NTH:
          begin
            evcRestart = qStart;
            evcInc = q && pat.srcEvt;
            fire = q && pat.srcEvt && (evcBase + 1'b1 == limN);
          end
          default: fire = 1'b0;
        endcase
      end
    end
  end

  // tracked state; cleared with the setup
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      have_r <= 1'b0;
      first_r <= 1'b1;
      qPrev_r <= 1'b0;
    end
    else if (clr_r)
    begin
      have_r <= 1'b0;
      first_r <= 1'b1;
      qPrev_r <= 1'b0;
    end
    else
    begin
      have_r <= have_nxt;
      first_r <= first_nxt;
      qPrev_r <= q;
    end
  end

  // trigger output and a wrapping trigger tally for software
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      trigOut <= 1'b0;
      trigCnt_r <= 8'h00;
    end
    else
    begin
      trigOut <= fire;
      if (fire)
        trigCnt_r <= trigCnt_r + 8'h01;
    end
  end

  trigger_registered_a: assert property (@(posedge clk) disable iff (!rstn)
    fire |=> trigOut)
    else $error("trigger decision not seen at the output");

  holdoff_time_a: assert property (@(posedge clk) disable iff (!rstn)
    (fire && !method && qual == PSTQ_Q_HTIME) |-> (first_r || tmr >= limT))
    else $error("time holdoff fired early");

  holdoff_restart_a: assert property (@(posedge clk) disable iff (!rstn)
    (fire && !method && qual == PSTQ_Q_HTIME) |=> tmr == ONE_T)
    else $error("holdoff timer not restarted by trigger");

  interval_less_a: assert property (@(posedge clk) disable iff (!rstn)
    (fire && !method && qual == PSTQ_Q_INTLT) |-> have_r && tmr < limT)
    else $error("interval less fired outside interval");

  interval_greater_a: assert property (@(posedge clk) disable iff (!rstn)
    (fire && !method && qual == PSTQ_Q_INTGT) |-> have_r && tmr > limT)
    else $error("interval greater fired too soon");

  gap_entry_a: assert property (@(posedge clk) disable iff (!rstn)
    (fire && !method && (qual == PSTQ_Q_GAPLT || qual == PSTQ_Q_GAPGT)) |-> pat.patEnter)
    else $error("gap test fired off entry");

  width_exit_a: assert property (@(posedge clk) disable iff (!rstn)
    (fire && !method && (qual == PSTQ_Q_WIDLT || qual == PSTQ_Q_WIDGT)) |-> pat.patExit)
    else $error("width test fired off exit");

  gap_restart_a: assert property (@(posedge clk) disable iff (!rstn)
    (enable && !clr_r && !method && (qual == PSTQ_Q_GAPLT || qual == PSTQ_Q_GAPGT) && pat.patExit)
    |=> tmr == ONE_T)
    else $error("gap timer not restarted on exit");

  state_source_a: assert property (@(posedge clk) disable iff (!rstn)
    (fire && method) |-> pat.srcEvt && q)
    else $error("state trigger without source edge in state");

  clear_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
    clr_r |=> !trigOut && tmr == ONE_T && evc == '0)
    else $error("clear did not quiet the qualifier");
endmodule

/* test/pstq_front_model.sv */
`timescale 1ns/1ps
module pstq_front_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic trigOut,
  output logic [2:0] chanAbove,
  output logic srcLevel
);
  int trigCount;
  // comparators idle low so reset sees no pattern entry
  initial
  begin
    chanAbove = 3'h0;
    srcLevel = 1'b0;
  end
  // trigger consumer: tally every pulse
  always @(posedge clk or negedge rstn)
    if (!rstn)
      trigCount <= 0;
    else if (trigOut)
      trigCount <= trigCount + 1;
  // levels move just after an edge, like a real comparator
  task automatic setChan(input logic [2:0] v);
    @(posedge clk);
    chanAbove <= v;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // source stays a separate pin, never part of the pattern
  task automatic pulseSrc(input int n);
    repeat (n)
    begin
      @(posedge clk);
      srcLevel <= 1'b1;
      idle(2);
      srcLevel <= 1'b0;
      idle(2);
    end
  endtask
endmodule

/* test/pstq_top_tb_top.sv */
`timescale 1ns/1ps
`include "pstq_defines.svh"
module pstq_top_tb_top;
  import pstq_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic waitrequest;
  logic [2:0] chanAbove;
  logic srcLevel;
  logic trigOut;
  int failures = 0;
  int comparisons = 0;
  int base;

  always #50 clk = ~clk;

  pstq_top pstq_top_i (
    .clk(clk),
    .rstn(rstn),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .chanAbove(chanAbove),
    .srcLevel(srcLevel),
    .trigOut(trigOut)
  );

  pstq_front_model pstq_front_model_i (
    .clk(clk),
    .rstn(rstn),
    .trigOut(trigOut),
    .chanAbove(chanAbove),
    .srcLevel(srcLevel)
  );

  task automatic wrap_up();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon access; request held until waitrequest sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      $display("wrong value at %0t: bus handshake timed out", $time);
      wrap_up();
    end
  endtask

  task automatic regWr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic regRd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h00000000, q);
  endtask

  task automatic checkTrig(input int exp);
    check(32'(pstq_front_model_i.trigCount - base), 32'(exp));
    base = pstq_front_model_i.trigCount;
  endtask

  // reset values and an unmapped read
  task automatic tResetVals();
    logic [31:0] q;
    regRd(`PSTQ_ADDR_CTRL, q);
    check(q, `PSTQ_CTRL_RST);
    regRd(`PSTQ_ADDR_TIME_LO, q);
    check(q, `PSTQ_TIME_LO_RST);
    regRd(`PSTQ_ADDR_TIME_HI, q);
    check(q, 32'h00000000);
    regWr(`PSTQ_ADDR_TIME_HI, 32'hFFFFFFFF);
    regRd(`PSTQ_ADDR_TIME_HI, q);
    check(q, 32'h00000001);
    regWr(`PSTQ_ADDR_TIME_HI, 32'h00000000);
    regRd(`PSTQ_ADDR_COUNT, q);
    check(q, 32'(`PSTQ_COUNT_RST));
    regWr(5'h14, 32'hFFFFFFFF);
    regRd(5'h14, q);
    check(q, 32'h00000000);
  endtask

  // ch1 above, ch2 below, ch3 ignored (code 3): all eight input combos
  task automatic tPattern();
    logic [31:0] q;
    regWr(`PSTQ_ADDR_CTRL, 32'h00003901);
    for (int v = 0; v < 8; v++)
    begin
      pstq_front_model_i.setChan(3'(v));
      pstq_front_model_i.idle(5);
      regRd(`PSTQ_ADDR_STATUS, q);
      check({31'h0, q[0]}, {31'h0, v[0] & !v[1]});
    end
  endtask

  // holdoff time 30 cycles: re-entry inside the holdoff is swallowed
  task automatic tHoldoff();
    pstq_front_model_i.setChan(3'h0);
    regWr(`PSTQ_ADDR_TIME_LO, 32'h0000001E);
    regWr(`PSTQ_ADDR_CTRL, 32'h00000101);
    pstq_front_model_i.idle(5);
    base = pstq_front_model_i.trigCount;
    pstq_front_model_i.setChan(3'h1);
    pstq_front_model_i.idle(8);
    checkTrig(1);
    pstq_front_model_i.setChan(3'h0);
    pstq_front_model_i.idle(3);
    pstq_front_model_i.setChan(3'h1);
    pstq_front_model_i.idle(8);
    checkTrig(0);
    pstq_front_model_i.setChan(3'h0);
    pstq_front_model_i.idle(40);
    pstq_front_model_i.setChan(3'h1);
    pstq_front_model_i.idle(8);
    checkTrig(1);
  endtask

  // pattern level lvl lasts w+1 cycles, then flips back
  task automatic segment(input logic lvl, input int w);
    pstq_front_model_i.setChan({2'h0, lvl});
    pstq_front_model_i.idle(w);
    pstq_front_model_i.setChan({2'h0, !lvl});
    pstq_front_model_i.idle(8);
  endtask

  // width tests time a high span, gap tests a low span; limit 10 cycles
  task automatic tSpan(input logic [31:0] ctrl, input logic lvl, input int shortHits);
    pstq_front_model_i.setChan({2'h0, !lvl});
    regWr(`PSTQ_ADDR_TIME_LO, 32'h0000000A);
    regWr(`PSTQ_ADDR_CTRL, ctrl);
    pstq_front_model_i.idle(10);
    base = pstq_front_model_i.trigCount;
    segment(lvl, 5);
    checkTrig(shortHits);
    segment(lvl, 20);
    checkTrig(1 - shortHits);
  endtask

  // event holdoff on exiting, count 2: the third exit after a trigger fires
  task automatic tHoldEvt();
    logic [31:0] q;
    pstq_front_model_i.setChan(3'h0);
    regWr(`PSTQ_ADDR_COUNT, 32'h00000002);
    regWr(`PSTQ_ADDR_CTRL, 32'h00000145);
    pstq_front_model_i.idle(5);
    base = pstq_front_model_i.trigCount;
    segment(1'b1, 4);
    checkTrig(1);
    segment(1'b1, 4);
    segment(1'b1, 4);
    checkTrig(0);
    segment(1'b1, 4);
    checkTrig(1);
    regRd(`PSTQ_ADDR_STATUS, q);
    check({16'h0, q[15:8], 5'h0, q[2:0]}, {16'h0, 8'(pstq_front_model_i.trigCount), 8'h02});
  endtask

  // interval tests on entries, limit 30 cycles: entries 12 apart, then 52
  task automatic tInterval(input logic [31:0] ctrl, input int shortHits);
    pstq_front_model_i.setChan(3'h0);
    regWr(`PSTQ_ADDR_TIME_LO, 32'h0000001E);
    regWr(`PSTQ_ADDR_CTRL, ctrl);
    pstq_front_model_i.idle(5);
    base = pstq_front_model_i.trigCount;
    segment(1'b1, 2);
    checkTrig(0);
    segment(1'b1, 2);
    checkTrig(shortHits);
    pstq_front_model_i.idle(40);
    segment(1'b1, 2);
    checkTrig(1 - shortHits);
  endtask

  // state method, wait (k=0) and and-before (k=1), 20 cycle window
  task automatic tStateTime(input int k);
    pstq_front_model_i.setChan(3'h0);
    regWr(`PSTQ_ADDR_TIME_LO, 32'h00000014);
    regWr(`PSTQ_ADDR_CTRL, 32'h00000123 + 32'(4 * k));
    pstq_front_model_i.idle(5);
    base = pstq_front_model_i.trigCount;
    pstq_front_model_i.setChan(3'h1);
    pstq_front_model_i.idle(1);
    pstq_front_model_i.pulseSrc(1);
    pstq_front_model_i.idle(4);
    checkTrig(k);
    pstq_front_model_i.idle(25);
    pstq_front_model_i.pulseSrc(1);
    pstq_front_model_i.idle(4);
    checkTrig(1 - k);
  endtask

  // nth event, count 3: fires once, never while pattern absent
  task automatic tNth();
    pstq_front_model_i.setChan(3'h0);
    regWr(`PSTQ_ADDR_COUNT, 32'h00000003);
    regWr(`PSTQ_ADDR_CTRL, 32'h0000012B);
    pstq_front_model_i.idle(5);
    base = pstq_front_model_i.trigCount;
    pstq_front_model_i.pulseSrc(3);
    checkTrig(0);
    pstq_front_model_i.setChan(3'h1);
    pstq_front_model_i.idle(6);
    pstq_front_model_i.pulseSrc(2);
    checkTrig(0);
    pstq_front_model_i.pulseSrc(1);
    pstq_front_model_i.idle(4);
    checkTrig(1);
    pstq_front_model_i.pulseSrc(2);
    checkTrig(0);
  endtask

  // nth event 1 while absent, falling slope: a falling edge in absence fires
  task automatic tAbsentFall();
    pstq_front_model_i.setChan(3'h1);
    regWr(`PSTQ_ADDR_COUNT, 32'h00000001);
    regWr(`PSTQ_ADDR_CTRL, 32'h000001EB);
    pstq_front_model_i.idle(5);
    base = pstq_front_model_i.trigCount;
    pstq_front_model_i.pulseSrc(1);
    pstq_front_model_i.idle(4);
    checkTrig(0);
    pstq_front_model_i.setChan(3'h0);
    pstq_front_model_i.idle(6);
    pstq_front_model_i.pulseSrc(1);
    pstq_front_model_i.idle(4);
    checkTrig(1);
    pstq_front_model_i.pulseSrc(1);
    pstq_front_model_i.idle(4);
    checkTrig(0);
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    tResetVals();
    tPattern();
    tHoldoff();
    tHoldEvt();
    tInterval(32'h00000109, 1);
    tInterval(32'h0000010D, 0);
    tSpan(32'h00000159, 1'b1, 1);
    tSpan(32'h0000015D, 1'b1, 0);
    tSpan(32'h00000111, 1'b0, 1);
    tSpan(32'h00000115, 1'b0, 0);
    tStateTime(0);
    tStateTime(1);
    tNth();
    tAbsentFall();
    wrap_up();
  end
endmodule
